//--- hw/rti_pa_map.svh
// Purpose: register indexes, field positions, reset values and counts
// Assumes: the register index is the word index on the bus
// Notes: byte address on the bus is four times the index
`ifndef RTI_PA_MAP_SVH
`define RTI_PA_MAP_SVH

// register indexes (bus address bits 15:2)
`define IDX_EVENT_MASK 14'h1024
`define IDX_EVENT_FLAGS 14'h1025
`define IDX_CONTROL 14'h1026
`define IDX_PULSE_COUNT 14'h1027

// flag and mask layout
`define BIT_TICK_FLAG 6
`define BIT_OVF_FLAG 5
`define BIT_EDGE_FLAG 4
`define FLAG_IMPL 8'h70

// control layout
`define BIT_ACC_EN 6
`define BIT_ACC_MODE 5
`define BIT_ACC_EDGE 4
`define BIT_CAPTURE_SEL 2
`define CTRL_IMPL 8'h77

// reset values
`define RESET_BYTE 8'h00
`define RESET_COUNT 8'h00

// clock period of the E clock in ns, and the division counts
`define E_PERIOD_NS 5
`define RTI_BASE_DIV 8192
`define GATE_DIV 64
`define GATE_DIV_LAST (`GATE_DIV - 1)

`endif

//--- hw/rti_pa_pkg.sv
// Purpose: shared types of the periodic interrupt and pulse accumulator
// Assumes: classic Wishbone with 32-bit data and 16-bit byte address
// Notes: numeric constants live in rti_pa_map.svh
package rti_pa_pkg;
   typedef logic [15:0] wb_addr_t;
   typedef logic [31:0] wb_data_t;
   typedef logic [3:0] wb_sel_t;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [1:0] {
      RATE_X1 = 2'b00,
      RATE_X2 = 2'b01,
      RATE_X4 = 2'b10,
      RATE_X8 = 2'b11
   } rate_e;
endpackage

//--- hw/rti_and_pulse_accumulator.sv
// Purpose: periodic interrupt unit and 8-bit pulse accumulator
// Assumes: REF_CLK_I is the E clock; registers sit in byte lane 0
// Notes: registered ack, one wait state on every access
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`include "rti_pa_map.svh"

// How it works
// - a base tick fires every 2^13 clock cycles from a free prescaler.
// - the rate field divides the base tick by 1, 2, 4 or 8.
// - reset leaves the rate field at 00, the fastest period.
// - the rate field is writable at any time with no lock.
// - each period end sets the periodic flag, which stays until cleared.
// - the interrupt is raised while the periodic flag and enable are set.
// - flag bits 3:0 read as zero and ignore writes.
// - control bits 7 and 3 always read as zero.
// - the enable, mode and edge bits are writable at any time.
// - the 8-bit count reads and loads directly at any time.
// - event mode counts each chosen edge of the input pin.
// - gated mode counts an E/64 tick while the pin level allows it.
// - rollover of the count to zero sets the overflow flag.
// - a chosen edge on the input pin sets the edge flag.
module rti_and_pulse_accumulator #(
   parameter int unsigned BASE_DIV = `RTI_BASE_DIV
) (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire rti_pa_pkg::wb_addr_t WB_ADR_I,
   input wire rti_pa_pkg::wb_sel_t WB_SEL_I,
   input wire rti_pa_pkg::wb_data_t WB_DAT_I,
   output rti_pa_pkg::wb_data_t WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic ACC_INPUT_PIN_I,
   output logic IRQ_O
);
   import rti_pa_pkg::*;

   // last values of the two prescalers before they wrap
   localparam logic [15:0] BASE_LAST = 16'(BASE_DIV - 1);
   localparam logic [5:0] GATE_LAST = 6'(`GATE_DIV_LAST);

   // bus state
   logic ack_q, ack_d;
   wb_data_t dat_q, dat_d;
   logic bus_hit;
   logic wr_lane;
   logic wr_mask, wr_flags, wr_ctrl, wr_count;
   reg_byte_t wr_byte;
   reg_byte_t rd_byte;

   // register state
   reg_byte_t mask_q, mask_d;
   reg_byte_t flags_q, flags_d;
   reg_byte_t ctrl_q, ctrl_d;
   reg_byte_t count_q, count_d;
   logic irq_q, irq_d;

   // timing state
   logic [15:0] base_cnt_q, base_cnt_d;
   logic [2:0] div_cnt_q, div_cnt_d;
   logic [5:0] gate_cnt_q, gate_cnt_d;
   logic base_tick, period_end, gate_tick;
   logic [2:0] div_mask;
   rate_e rate;

   // input pin state
   logic pin_meta_q, pin_sync_q, pin_prev_q;
   logic pin_meta_d, pin_sync_d, pin_prev_d;
   logic pin_rise, pin_fall, edge_hit, gate_open;

   // accumulator control decode
   logic acc_en, acc_gated, acc_edge;
   logic count_inc;
   reg_byte_t flag_set, flag_clr;

   // control fields as the counter and divider logic see them
   assign acc_en = ctrl_q[`BIT_ACC_EN];
   assign acc_gated = ctrl_q[`BIT_ACC_MODE];
   assign acc_edge = ctrl_q[`BIT_ACC_EDGE];
   assign rate = rate_e'(ctrl_q[1:0]);

   // --- Wishbone slave ---

   // ack one cycle after the request and never two in a row;
   // a master that holds cyc and stb gets a new ack every other cycle
   assign bus_hit = WB_CYC_I & WB_STB_I;
   // only lane 0 carries a register; a write with sel[0] low still
   // gets its ack but changes nothing
   assign wr_lane = bus_hit & WB_WE_I & WB_SEL_I[0] & ack_q;
   assign wr_byte = WB_DAT_I[7:0];

   // writes land at the edge where the master samples ack
   always_comb begin
      wr_mask = wr_lane & (WB_ADR_I[15:2] == `IDX_EVENT_MASK);
      wr_flags = wr_lane & (WB_ADR_I[15:2] == `IDX_EVENT_FLAGS);
      wr_ctrl = wr_lane & (WB_ADR_I[15:2] == `IDX_CONTROL);
      wr_count = wr_lane & (WB_ADR_I[15:2] == `IDX_PULSE_COUNT);
   end

   // read mux; unmapped words read as zero
   // reads have no side effect; a flag clears only by a written one
   always_comb begin
      unique case (WB_ADR_I[15:2])
         `IDX_EVENT_MASK: rd_byte = mask_q;
         `IDX_EVENT_FLAGS: rd_byte = flags_q & `FLAG_IMPL;
         `IDX_CONTROL: rd_byte = ctrl_q & `CTRL_IMPL;
         `IDX_PULSE_COUNT: rd_byte = count_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // ack and read data next values
   // the answer is registered to keep the read path off the output;
   // read data is captured with the ack and then held, so a late
   // sample by the master still sees the answer
   always_comb begin
      ack_d = bus_hit & ~ack_q;
      dat_d = dat_q;
      if (ack_d) begin
         dat_d = {24'h000000, rd_byte};
      end
   end

   // bus registers
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;

   // --- periodic interrupt timing ---

   // base prescaler runs free of any other timer setting
   // with the default count the base tick comes once in 8192 cycles
   always_comb begin
      base_tick = (base_cnt_q == BASE_LAST);
      base_cnt_d = base_tick ? 16'h0000 : 16'(base_cnt_q + 16'h0001);
      div_cnt_d = base_tick ? 3'(div_cnt_q + 3'h1) : div_cnt_q;
   end

   // the rate field picks how many base ticks make a period
   // the divider counts base ticks and wraps at eight; a period ends
   // when the low divider bits picked by the rate are all ones
   always_comb begin
      unique case (rate)
         RATE_X1: div_mask = 3'h0;
         RATE_X2: div_mask = 3'h1;
         RATE_X4: div_mask = 3'h3;
         RATE_X8: div_mask = 3'h7;
      endcase
      period_end = base_tick & ((div_cnt_q & div_mask) == div_mask);
   end

   // a rate change mid-period takes the running divider as it stands,
   // so the first period after it may be shorter than nominal
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         base_cnt_q <= 16'h0000;
         div_cnt_q <= 3'h0;
      end else begin
         base_cnt_q <= base_cnt_d;
         div_cnt_q <= div_cnt_d;
      end
   end

   // --- input pin synchroniser and edge detect ---

   // shift chain next values; the first stage feeds nothing but the
   // second, so a metastable sample never reaches the counter
   always_comb begin
      pin_meta_d = ACC_INPUT_PIN_I;
      pin_sync_d = pin_meta_q;
      pin_prev_d = pin_sync_q;
   end

   // the edge detector reads only the second and third stage; all
   // three reset low like the idle pin, so no false edge follows
   // the release of reset
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
         pin_prev_q <= pin_prev_d;
      end
   end

   // edge select: 0 picks falling, 1 picks rising; in gated mode
   // the same edge is the trailing edge of the open gate;
   // a change of the select alone never makes an edge, since the
   // detector compares two samples of the pin
   always_comb begin
      pin_rise = pin_sync_q & ~pin_prev_q;
      pin_fall = ~pin_sync_q & pin_prev_q;
      edge_hit = acc_edge ? pin_rise : pin_fall;
      gate_open = acc_edge ? ~pin_sync_q : pin_sync_q;
   end

   // --- pulse accumulator ---

   // free-running E/64 prescaler for gated accumulation
   // it is not restarted by the gate, so a short open window may
   // see no tick at all
   always_comb begin
      gate_tick = (gate_cnt_q == GATE_LAST);
      gate_cnt_d = 6'(gate_cnt_q + 6'h01);
   end

   // gate prescaler register; the first count after the gate opens
   // may come anywhere from 1 to 64 cycles later
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         gate_cnt_q <= 6'h00;
      end else begin
         gate_cnt_q <= gate_cnt_d;
      end
   end

   // count source by mode; a software load wins over an increment
   // so that a load and a rollover never meet; the overflow flag
   // below relies on this ordering
   always_comb begin
      if (acc_gated) begin
         count_inc = acc_en & gate_open & gate_tick;
      end else begin
         count_inc = acc_en & edge_hit;
      end
      count_d = count_q;
      if (wr_count) begin
         count_d = wr_byte;
      end else if (count_inc) begin
         count_d = 8'(count_q + 8'h01);
      end
   end

   // the count clears at reset with the rest of the block
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         count_q <= `RESET_COUNT;
      end else begin
         count_q <= count_d;
      end
   end

   // --- flags, mask and control ---

   // hardware set beats a same-cycle software clear
   // an overflow needs a real increment: a load in the same cycle
   // wins and takes no flag with it
   always_comb begin
      flag_set = 8'h00;
      flag_set[`BIT_TICK_FLAG] = period_end;
      flag_set[`BIT_OVF_FLAG] = count_inc & ~wr_count &
                                (count_q == 8'hff);
      flag_set[`BIT_EDGE_FLAG] = acc_en & edge_hit;
      flag_clr = wr_flags ? wr_byte : 8'h00;
      flags_d = ((flags_q & ~flag_clr) | flag_set) & `FLAG_IMPL;
   end

   // control bits change on any write, no lock window
   // the mask holds the three interrupt enables in the flag layout;
   // unused bits are dropped on write so they read back as zero
   always_comb begin
      ctrl_d = wr_ctrl ? (wr_byte & `CTRL_IMPL) : ctrl_q;
      mask_d = wr_mask ? (wr_byte & `FLAG_IMPL) : mask_q;
      irq_d = |(flags_q & mask_q);
   end

   // reset clears all, leaving the fastest periodic rate
   // count, prescalers and bus state reset in their own processes
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         flags_q <= `RESET_BYTE;
         ctrl_q <= `RESET_BYTE;
         mask_q <= `RESET_BYTE;
         irq_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   // registered, so it trails the flag by one cycle
   // a level output: it drops one cycle after the last unmasked
   // flag is cleared
   assign IRQ_O = irq_q;

endmodule

//--- tb/rti_pa_chk.sv
// Purpose: bus timing and readback checks at the block ports
// Assumes: registered ack, registers in byte lane 0
// Notes: bound to the block below
`timescale 1ns/10ps
`include "rti_pa_map.svh"
module rti_pa_chk (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire rti_pa_pkg::wb_addr_t WB_ADR_I,
   input wire rti_pa_pkg::wb_data_t WB_DAT_O,
   input wire logic WB_ACK_O
);
   import rti_pa_pkg::*;
   logic rd;
   logic [13:0] ix;
   // a read answer and the index it belongs to
   assign rd = WB_ACK_O & ~WB_WE_I;
   assign ix = WB_ADR_I[15:2];
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   a_ack_next: assert property (WB_CYC_I & WB_STB_I & !WB_ACK_O
      |=> WB_ACK_O) else $error("ack late");
   a_ack_single: assert property ($rose(WB_ACK_O) |=> $fell(WB_ACK_O))
      else $error("ack held");
   a_ack_idle: assert property (!WB_CYC_I |=> !WB_ACK_O)
      else $error("ack with no cycle");
   a_rd_upper: assert property (rd |-> WB_DAT_O[31:8] == 24'h0)
      else $error("upper lanes not zero");
   a_flag_holes: assert property (rd && ix == `IDX_EVENT_FLAGS
      |-> (WB_DAT_O[7:0] & ~`FLAG_IMPL) == 8'h00) else $error("flag hole");
   a_mask_holes: assert property (rd && ix == `IDX_EVENT_MASK
      |-> (WB_DAT_O[7:0] & ~`FLAG_IMPL) == 8'h00) else $error("mask hole");
   a_ctrl_holes: assert property (rd && ix == `IDX_CONTROL
      |-> (WB_DAT_O[7:0] & ~`CTRL_IMPL) == 8'h00) else $error("ctrl hole");
   a_unmapped_zero: assert property (rd && (ix < `IDX_EVENT_MASK
      || ix > `IDX_PULSE_COUNT) |-> WB_DAT_O == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind rti_and_pulse_accumulator rti_pa_chk u_chk (.REF_CLK_I, .RESET_N_I,
   .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O);

//--- tb/rti_pa_src.sv
// Purpose: pulse source on the accumulator input pin
// Assumes: go_i is a one-cycle request
// Notes: pulses shorter than two clocks may be missed, so w_i >= 3
`timescale 1ns/10ps
module rti_pa_src (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [7:0] n_i,
   input wire logic [15:0] w_i,
   output logic pin_o,
   output logic busy_o
);
   // n_i pulses, each w_i cycles high then w_i low, moved after edges
   initial begin
      pin_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            busy_o <= 1'b1;
            repeat (n_i) begin
               pin_o <= 1'b1;
               repeat (w_i) @(posedge clk_i);
               pin_o <= 1'b0;
               repeat (w_i) @(posedge clk_i);
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule

//--- tb/rti_and_pulse_accumulator_tb_top.sv
// Purpose: random and corner tests of the periodic and pulse units
// Assumes: BD shortens the periodic base to keep the run short
// Notes: ack, data and irq are sampled as they stood before each edge
`timescale 1ns/10ps
`include "rti_pa_map.svh"
module rti_and_pulse_accumulator_tb_top;
   import rti_pa_pkg::*;
   localparam int BD = 16;
   logic clk, rst_n, cyc, stb, we, ack, pin, irq, go, busy;
   wb_addr_t adr;
   wb_sel_t sel, sl;
   wb_data_t dat_i, dat_o;
   logic [7:0] n;
   logic [15:0] w;
   reg_byte_t q, s, e;
   reg_byte_t tbl [3] = '{8'h10, 8'h40, 8'h50};
   int n_errors, checks, cyc_n, c, t0, t1;
   rti_and_pulse_accumulator #(.BASE_DIV(BD)) dut (.REF_CLK_I(clk),
      .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .ACC_INPUT_PIN_I(pin), .IRQ_O(irq));
   rti_pa_src src (.clk_i(clk), .go_i(go), .n_i(n), .w_i(w),
      .pin_o(pin), .busy_o(busy));
   // free clock and a cycle count for period measurement
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc_n <= cyc_n + 1;
   function automatic reg_byte_t ev_flags(reg_byte_t s0, int c0, logic en);
      return en ? {2'b00, int'(s0) + c0 > 255, 5'h10} : 8'h00;
   endfunction
   task automatic chk(input reg_byte_t sn, input reg_byte_t ex);
      checks++;
      if (sn !== ex) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, sn, ex);
      end
   endtask
   task automatic fail();
      n_errors++;
      wrap_up();
   endtask
   // one classic cycle; held until ack is seen, then one idle cycle
   task automatic wb(input logic w_en, input logic [13:0] ix,
                     input reg_byte_t d);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      adr <= {ix, 2'b00};
      sel <= sl;
      dat_i <= {24'h0, d};
      for (k = 0; ack !== 1'b1; k++) begin
         @(posedge clk);
         if (k > 99) fail();
      end
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [13:0] ix, input reg_byte_t d);
      wb(1'b1, ix, d);
   endtask
   task automatic rd(input logic [13:0] ix, input reg_byte_t m, ex);
      wb(1'b0, ix, 8'h00);
      chk(q & m, ex);
   endtask
   // bounded wait for busy (sb=1) or irq (sb=0) to reach v
   task automatic wt(input bit sb, input logic v);
      int k;
      for (k = 0; (sb ? busy : irq) !== v; k++) begin
         @(posedge clk);
         if (k > 999) fail();
      end
   endtask
   task automatic pulses(input int n0, input int w0);
      n <= 8'(n0);
      w <= 16'(w0);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      wt(1'b1, 1'b0);
      repeat (6) @(posedge clk);
   endtask
   // periodic flag rise seen at irq, time noted, flag cleared
   task automatic tick();
      wt(1'b0, 1'b0);
      wt(1'b0, 1'b1);
      t1 = cyc_n;
      wr(`IDX_EVENT_FLAGS, 8'h40);
   endtask
   task automatic wrap_up();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {cyc, stb, we, go, rst_n, adr, sel, dat_i, n, w} = '0;
      sl = 4'h1;
      void'($urandom(38074));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (c = 'h1024; c < 'h1029; c++) begin
         rd(14'(c), 8'hff, 8'h00);
      end
      $display("reset test done");
      wr(`IDX_CONTROL, 8'hff);
      rd(`IDX_CONTROL, 8'hff, `CTRL_IMPL);
      repeat (4) begin
         s = 8'($urandom);
         wr(`IDX_CONTROL, s);
         rd(`IDX_CONTROL, 8'hff, s & `CTRL_IMPL);
      end
      wr(`IDX_CONTROL, 8'h00);
      wr(`IDX_EVENT_FLAGS, 8'h0f);
      rd(`IDX_EVENT_FLAGS, 8'h8f, 8'h00);
      s = 8'($urandom);
      wr(`IDX_PULSE_COUNT, s);
      rd(`IDX_PULSE_COUNT, 8'hff, s);
      sl = 4'h0;
      wr(`IDX_PULSE_COUNT, ~s);
      sl = 4'h1;
      rd(`IDX_PULSE_COUNT, 8'hff, s);
      $display("register test done");
      wr(`IDX_EVENT_MASK, 8'h10);
      foreach (tbl[i]) begin
         wr(`IDX_CONTROL, tbl[i]);
         wr(`IDX_EVENT_FLAGS, 8'h30);
         s = 8'hf8 + 8'($urandom % 8);
         c = 1 + $urandom % 12;
         wr(`IDX_PULSE_COUNT, s);
         pulses(c, 3);
         e = ev_flags(s, c, tbl[i][6]);
         rd(`IDX_PULSE_COUNT, 8'hff, tbl[i][6] ? s + 8'(c) : s);
         rd(`IDX_EVENT_FLAGS, 8'h30, e);
         chk({7'h0, irq}, {7'h0, tbl[i][6]});
      end
      wr(`IDX_EVENT_FLAGS, 8'h00);
      rd(`IDX_EVENT_FLAGS, 8'h30, e);
      wr(`IDX_EVENT_FLAGS, 8'h30);
      rd(`IDX_EVENT_FLAGS, 8'h30, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("event test done");
      wr(`IDX_EVENT_MASK, 8'h40);
      for (c = 0; c < 4; c++) begin
         wr(`IDX_CONTROL, 8'(c));
         wr(`IDX_EVENT_FLAGS, 8'h40);
         tick();
         tick();
         t0 = t1;
         tick();
         chk(8'(t1 - t0), 8'(BD << c));
      end
      $display("periodic test done");
      wr(`IDX_EVENT_MASK, 8'h00);
      wr(`IDX_CONTROL, 8'h60);
      wr(`IDX_PULSE_COUNT, 8'h00);
      wr(`IDX_EVENT_FLAGS, 8'h10);
      pulses(1, 3 * `GATE_DIV);
      rd(`IDX_PULSE_COUNT, 8'hff, 8'h03);
      rd(`IDX_EVENT_FLAGS, 8'h10, 8'h10);
      $display("gated test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`IDX_CONTROL, 8'hff, 8'h00);
      $display("second reset test done");
      wrap_up();
   end
endmodule
